/* File: hdl/t2c_consts.vh */
// register offsets, field positions, reset values and timing counts for the timer
`ifndef T2C_CONSTS_VH
`define T2C_CONSTS_VH

// apb byte offsets
`define T2C_OFF_CTRL      12'h000
`define T2C_OFF_CLKSEL    12'h004
`define T2C_OFF_CNT       12'h008
`define T2C_OFF_RELOAD    12'h00C
`define T2C_OFF_IRQ_STAT  12'h010
`define T2C_OFF_IRQ_MASK  12'h014
`define T2C_OFF_IRQ_EN    12'h018

// control register fields
`define T2C_B_HOVF        7
`define T2C_B_LOVF        6
`define T2C_B_LIRQ_EN     5
`define T2C_B_CAP_EN      4
`define T2C_B_SPLIT       3
`define T2C_B_RUN         2
`define T2C_B_XSEL_HI     1
`define T2C_B_XSEL_LO     0

// clock select register fields
`define T2C_B_HCLK_SEL    1
`define T2C_B_LCLK_SEL    0

// status / mask bit positions
`define T2C_I_HOVF        0
`define T2C_I_LOVF        1
`define T2C_I_CAP         2

// reset values
`define T2C_RST_CTRL      8'h00
`define T2C_RST_BYTE      8'h00

// source select codes
`define T2C_XSEL_RTC      2'h3
`define T2C_XSEL_CMP_MIN  2'h2

// dividers
`define T2C_SYS_DIV       12
`define T2C_RTC_DIV       8
`define T2C_SYS_DIV_LAST  4'hB
`define T2C_RTC_DIV_LAST  3'h7

`endif

/* File: hdl/t2c_div.v */
// prescalers: system clock divided by 12 and rtc edges divided by 8
`timescale 1ns/10ps
`include "t2c_consts.vh"

module t2c_div
(
   // clock and reset
   input  wire clock,
   input  wire resetn,
   // synchronised rtc rising edge
   input  wire rtc_tick,
   // one-cycle ticks
   output wire sys12_tick,
   output wire rtc8_tick
);

   reg [3:0] sys_cnt_r;
   reg [2:0] rtc_cnt_r;

   // free-running dividers so the ticks never depend on mode changes
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         sys_cnt_r <= 4'h0;
         rtc_cnt_r <= 3'h0;
      end
      else
      begin
         if (sys_cnt_r == `T2C_SYS_DIV_LAST)
            sys_cnt_r <= 4'h0;
         else
            sys_cnt_r <= sys_cnt_r + 4'h1;
         if (rtc_tick)
            rtc_cnt_r <= rtc_cnt_r + 3'h1;
      end
   end

   assign sys12_tick = (sys_cnt_r == `T2C_SYS_DIV_LAST);
   assign rtc8_tick  = rtc_tick & (rtc_cnt_r == `T2C_RTC_DIV_LAST);

endmodule // t2c_div

/* File: hdl/t2c_sync.v */
// two-flip-flop synchroniser with rising-edge pulse behind it
`timescale 1ns/10ps

module t2c_sync
(
   // clock and reset
   input  wire clock,
   input  wire resetn,
   // async level in, edge pulse out
   input  wire async_in,
   output wire rise_pulse
);

   reg meta_r;
   reg sync_r;
   reg prev_r;

   // only sync_r and prev_r are looked at; meta_r feeds sync_r alone
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end
      else
      begin
         meta_r <= async_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign rise_pulse = sync_r & ~prev_r;

endmodule // t2c_sync

/* File: hdl/t2c_timer.v */
// auto-reload 8/16-bit timer with capture, control register and apb slave
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "t2c_consts.vh"

module t2c_timer
(
   // clock and reset
   input  wire        clock,
   input  wire        resetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output reg  [31:0] prdata,
   output wire        pslverr,
   // asynchronous sources
   input  wire        rtc_clock_in,
   input  wire        comparator0_in,
   // interrupt
   output wire        irq
);

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   reg  [7:0]  ctrl_r;
   reg  [1:0]  clksel_r;
   reg  [7:0]  cnt_lo_r;
   reg  [7:0]  cnt_hi_r;
   reg  [7:0]  rld_lo_r;
   reg  [7:0]  rld_hi_r;
   reg  [2:0]  stat_r;
   reg  [2:0]  mask_r;
   reg         timer_irq_en_r;
   reg         rld_lo_pend_r;
   reg         rld_hi_pend_r;
   reg  [7:0]  ctrl_nxt;
   reg  [2:0]  stat_nxt;

   wire        rtc_rise;
   wire        cmp_rise;
   wire        sys12_tick;
   wire        rtc8_tick;

   // ------------------------------------------------------------------
   // source synchronisation and prescale
   // ------------------------------------------------------------------
   // async pins pass two flops before any edge logic
   t2c_sync u_sync_rtc (
      .clock      (clock),
      .resetn     (resetn),
      .async_in   (rtc_clock_in),
      .rise_pulse (rtc_rise)
   );

   t2c_sync u_sync_cmp (
      .clock      (clock),
      .resetn     (resetn),
      .async_in   (comparator0_in),
      .rise_pulse (cmp_rise)
   );

   t2c_div u_div (
      .clock      (clock),
      .resetn     (resetn),
      .rtc_tick   (rtc_rise),
      .sys12_tick (sys12_tick),
      .rtc8_tick  (rtc8_tick)
   );

   // ------------------------------------------------------------------
   // clock and trigger selection
   // ------------------------------------------------------------------
   wire [1:0] xsel    = ctrl_r[`T2C_B_XSEL_HI:`T2C_B_XSEL_LO];
   wire       split   = ctrl_r[`T2C_B_SPLIT];
   wire       run     = ctrl_r[`T2C_B_RUN];
   wire       cap_en  = ctrl_r[`T2C_B_CAP_EN];
   wire       ext_tick = (xsel == `T2C_XSEL_RTC) ? rtc8_tick : sys12_tick;
   wire       cap_trig = (xsel >= `T2C_XSEL_CMP_MIN) ? cmp_rise : rtc8_tick;

   // each byte chooses between external tick and system clock
   wire       lo_src  = clksel_r[`T2C_B_LCLK_SEL] ? 1'b1 : ext_tick;
   wire       hi_src  = clksel_r[`T2C_B_HCLK_SEL] ? 1'b1 : ext_tick;

   // in 16-bit mode the low byte select drives the whole counter
   wire       lo_tick = split ? lo_src : (run & lo_src);
   wire       hi_tick = split ? (run & hi_src) : 1'b0;

   // capture mode freezes reload behaviour and latches on the trigger
   wire       cap_evt = cap_en & cap_trig;

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   // zero wait states: every access completes in its access phase
   wire       acc   = psel & penable;
   wire       wr    = acc & pwrite;
   wire       hit   = (paddr == `T2C_OFF_CTRL)     || (paddr == `T2C_OFF_CLKSEL) ||
                      (paddr == `T2C_OFF_CNT)      || (paddr == `T2C_OFF_RELOAD) ||
                      (paddr == `T2C_OFF_IRQ_STAT) || (paddr == `T2C_OFF_IRQ_MASK) ||
                      (paddr == `T2C_OFF_IRQ_EN);
   wire       wr_ctrl = wr & (paddr == `T2C_OFF_CTRL);
   wire       wr_cnt  = wr & (paddr == `T2C_OFF_CNT);
   wire       wr_rld  = wr & (paddr == `T2C_OFF_RELOAD);

   assign pready  = 1'b1;
   assign pslverr = acc & ~hit;

   // ------------------------------------------------------------------
   // counters
   // ------------------------------------------------------------------
   wire lo_wrap  = lo_tick & ~rld_lo_pend_r & (cnt_lo_r == 8'hFF);
   wire hi_wrap8 = hi_tick & ~rld_hi_pend_r & (cnt_hi_r == 8'hFF);
   wire wrap16   = ~split & lo_wrap & (cnt_hi_r == 8'hFF);
   wire hi_ovf   = split ? hi_wrap8 : wrap16;

   // a wrap passes through 0x00, then the next count clock loads reload
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_lo_r      <= `T2C_RST_BYTE;
         cnt_hi_r      <= `T2C_RST_BYTE;
         rld_lo_pend_r <= 1'b0;
         rld_hi_pend_r <= 1'b0;
      end
      else if (wr_cnt)
      begin
         cnt_lo_r      <= pwdata[7:0];
         cnt_hi_r      <= pwdata[15:8];
         rld_lo_pend_r <= 1'b0;
         rld_hi_pend_r <= 1'b0;
      end
      else
      begin
         if (lo_tick)
         begin
            if (rld_lo_pend_r)
            begin
               cnt_lo_r      <= rld_lo_r;
               rld_lo_pend_r <= 1'b0;
               if (!split)
               begin
                  cnt_hi_r      <= rld_hi_r;
                  rld_hi_pend_r <= 1'b0;
               end
            end
            else
            begin
               cnt_lo_r <= cnt_lo_r + 8'h01;
               if (!split && cnt_lo_r == 8'hFF)
                  cnt_hi_r <= cnt_hi_r + 8'h01;
               // in capture mode the reload register holds captures, so free-run
               if (split && lo_wrap && !cap_en)
                  rld_lo_pend_r <= 1'b1;
               if (wrap16 && !cap_en)
                  rld_lo_pend_r <= 1'b1;
            end
         end
         if (hi_tick)
         begin
            if (rld_hi_pend_r)
            begin
               cnt_hi_r      <= rld_hi_r;
               rld_hi_pend_r <= 1'b0;
            end
            else
            begin
               cnt_hi_r <= cnt_hi_r + 8'h01;
               if (hi_wrap8 && !cap_en)
                  rld_hi_pend_r <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // reload / capture register
   // ------------------------------------------------------------------
   // a capture in the same cycle as a software write wins: it is the event
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         rld_lo_r <= `T2C_RST_BYTE;
         rld_hi_r <= `T2C_RST_BYTE;
      end
      else if (cap_evt)
      begin
         rld_lo_r <= cnt_lo_r;
         rld_hi_r <= cnt_hi_r;
      end
      else if (wr_rld)
      begin
         rld_lo_r <= pwdata[7:0];
         rld_hi_r <= pwdata[15:8];
      end
   end

   // ------------------------------------------------------------------
   // control register with overflow flags
   // ------------------------------------------------------------------
   // software may write the flags either way; hardware sets win the cycle
   always @*
   begin
      ctrl_nxt = ctrl_r;
      if (wr_ctrl)
         ctrl_nxt = pwdata[7:0];
      if (hi_ovf || cap_evt)
         ctrl_nxt[`T2C_B_HOVF] = 1'b1;
      if (lo_wrap)
         ctrl_nxt[`T2C_B_LOVF] = 1'b1;
   end

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_r         <= `T2C_RST_CTRL;
         clksel_r       <= 2'h0;
         mask_r         <= 3'h0;
         timer_irq_en_r <= 1'b0;
      end
      else
      begin
         ctrl_r <= ctrl_nxt;
         if (wr && paddr == `T2C_OFF_CLKSEL)
            clksel_r <= pwdata[1:0];
         if (wr && paddr == `T2C_OFF_IRQ_MASK)
            mask_r <= pwdata[2:0];
         if (wr && paddr == `T2C_OFF_IRQ_EN)
            timer_irq_en_r <= pwdata[0];
      end
   end

   // ------------------------------------------------------------------
   // interrupt status
   // ------------------------------------------------------------------
   // write one to clear; a new event in the clearing cycle stays set
   always @*
   begin
      stat_nxt = stat_r;
      if (wr && paddr == `T2C_OFF_IRQ_STAT)
         stat_nxt = stat_r & ~pwdata[2:0];
      if (hi_ovf)
         stat_nxt[`T2C_I_HOVF] = 1'b1;
      if (lo_wrap && ctrl_r[`T2C_B_LIRQ_EN])
         stat_nxt[`T2C_I_LOVF] = 1'b1;
      if (cap_evt)
         stat_nxt[`T2C_I_CAP] = 1'b1;
   end

   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         stat_r <= 3'h0;
      else
         stat_r <= stat_nxt;
   end

   // the timer-level enable gates the whole group
   assign irq = timer_irq_en_r & |(stat_r & mask_r);

   // ------------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------------
   always @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
      begin
         if (paddr == `T2C_OFF_CTRL)
            prdata <= {24'h000000, ctrl_r};
         else if (paddr == `T2C_OFF_CLKSEL)
            prdata <= {30'h00000000, clksel_r};
         else if (paddr == `T2C_OFF_CNT)
            prdata <= {16'h0000, cnt_hi_r, cnt_lo_r};
         else if (paddr == `T2C_OFF_RELOAD)
            prdata <= {16'h0000, rld_hi_r, rld_lo_r};
         else if (paddr == `T2C_OFF_IRQ_STAT)
            prdata <= {29'h00000000, stat_r};
         else if (paddr == `T2C_OFF_IRQ_MASK)
            prdata <= {29'h00000000, mask_r};
         else if (paddr == `T2C_OFF_IRQ_EN)
            prdata <= {31'h00000000, timer_irq_en_r};
         else
            prdata <= 32'h00000000;
      end
   end

endmodule // t2c_timer

/* File: tb/t2c_timer_properties.sv */
// assertion checker for the timer block's apb and interrupt ports
`timescale 1ns/10ps

module t2c_timer_properties
(
   // clock and reset
   input wire        clock,
   input wire        resetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire [31:0] prdata,
   input wire        pslverr,
   // sources and interrupt
   input wire        rtc_clock_in,
   input wire        comparator0_in,
   input wire        irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   // -------------------------------------------------------------
   // address decode and bus steps
   // -------------------------------------------------------------
   // only aligned words up to the interrupt enable are mapped
   wire mapped = (paddr[1:0] == 2'h0) && (paddr <= 12'h018);
   sequence s_access;
      psel && penable;
   endsequence
   sequence s_wr(logic [11:0] a);
      psel && penable && pwrite && (paddr == a);
   endsequence

   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   chk_pready_high: assert property (pready)
      else $error("pready low");
   chk_err_idle: assert property (!(psel && penable) |-> !pslverr)
      else $error("pslverr outside access");
   chk_err_unmapped: assert property (s_access ##0 !mapped |-> pslverr)
      else $error("no error on unmapped access");
   chk_ok_mapped: assert property (s_access ##0 mapped |-> !pslverr)
      else $error("error on mapped access");
   chk_rd_unmapped: assert property (s_access ##0 (!pwrite && !mapped) |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   // read data may only move when a read setup is taken
   chk_rd_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
      else $error("read data moved without read");
   chk_irq_en_off: assert property (s_wr(12'h018) ##0 !pwdata[0] |=> !irq)
      else $error("irq stays with timer irq disabled");
   chk_irq_mask_off: assert property (s_wr(12'h014) ##0 (pwdata[2:0] == 3'h0) |=> !irq)
      else $error("irq stays with all sources masked");
endmodule // t2c_timer_properties

/* File: tb/tb_top.sv */
// self-checking bench for the timer: registers, wrap, split, rtc count, capture
`timescale 1ns/10ps
`include "t2c_consts.vh"

module tb_top;
   reg         clock          = 1'b0;
   reg         resetn         = 1'b0;
   reg         psel           = 1'b0;
   reg         penable        = 1'b0;
   reg         pwrite         = 1'b0;
   reg  [11:0] paddr          = 12'h000;
   reg  [31:0] pwdata         = 32'h0;
   reg         rtc_clock_in   = 1'b0;
   reg         comparator0_in = 1'b0;
   wire        pready;
   wire [31:0] prdata;
   wire        pslverr;
   wire        irq;
   reg  [31:0] rd;
   reg         er;
   integer     failures  = 0;
   integer     cmp_count = 0;
   integer     cyc       = 0;
   integer     i;

   always #2 clock = ~clock;

   t2c_timer uut (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .rtc_clock_in(rtc_clock_in), .comparator0_in(comparator0_in),
      .irq(irq));

   // -------------------------------------------------------------
   // bus and compare tasks
   // -------------------------------------------------------------
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp)
         begin
            failures = failures + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // an edge passes first so back-to-back calls never drive psel twice at once
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge clock);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         @(posedge clock);
         while (pready !== 1'b1)
            @(posedge clock);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wr(input [11:0] a, input [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input [11:0] a, input [31:0] e);
      begin
         apb(1'b0, a, 32'h0);
         cmp(rd, e);
      end
   endtask
   // read until a masked bit shows; the cycle ceiling cuts a hang
   task poll(input [11:0] a, input [31:0] m);
      begin
         apb(1'b0, a, 32'h0);
         while ((rd & m) == 32'h0)
            apb(1'b0, a, 32'h0);
      end
   endtask
   task irq_is(input e);
      begin
         @(negedge clock);
         cmp(irq, e);
      end
   endtask
   task rtc_pulses(input integer n);
      repeat (n)
      begin
         repeat (3) @(posedge clock);
         rtc_clock_in <= 1'b1;
         repeat (3) @(posedge clock);
         rtc_clock_in <= 1'b0;
      end
   endtask

   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task s_regs;
      begin
         for (i = 0; i < 7; i = i + 1)
            rdc(12'(i * 4), 32'h0);
         apb(1'b0, 12'h01C, 32'h0);
         cmp(er, 1'b1);
      end
   endtask
   task s_wrap16;
      begin
         wr(`T2C_OFF_CNT, 32'hFFFE);
         wr(`T2C_OFF_RELOAD, 32'h1234);
         wr(`T2C_OFF_CTRL, 32'h04);
         poll(`T2C_OFF_CTRL, 32'h80);
         cmp(rd, 32'hC4);
         poll(`T2C_OFF_CNT, 32'hFFFF);
         cmp(rd, 32'h1234);
      end
   endtask
   task s_split;
      begin
         wr(`T2C_OFF_CTRL, 32'h0);
         wr(`T2C_OFF_IRQ_STAT, 32'h7);
         wr(`T2C_OFF_IRQ_EN, 32'h1);
         wr(`T2C_OFF_IRQ_MASK, 32'h2);
         wr(`T2C_OFF_CNT, 32'h50FE);
         wr(`T2C_OFF_RELOAD, 32'h7780);
         wr(`T2C_OFF_CTRL, 32'h29);
         poll(`T2C_OFF_CTRL, 32'h40);
         cmp(rd, 32'h69);
         irq_is(1'b1);
         poll(`T2C_OFF_CNT, 32'h00FF);
         cmp(rd, 32'h5080);
         wr(`T2C_OFF_IRQ_MASK, 32'h0);
         irq_is(1'b0);
         wr(`T2C_OFF_IRQ_MASK, 32'h2);
         irq_is(1'b1);
         wr(`T2C_OFF_IRQ_STAT, 32'h2);
         irq_is(1'b0);
      end
   endtask
   task s_rtc;
      begin
         wr(`T2C_OFF_CTRL, 32'h0);
         wr(`T2C_OFF_CNT, 32'h0);
         wr(`T2C_OFF_CTRL, 32'h07);
         rtc_pulses(16);
         repeat (8) @(posedge clock);
         rdc(`T2C_OFF_CNT, 32'h2);
      end
   endtask
   task s_capture;
      begin
         wr(`T2C_OFF_CTRL, 32'h0);
         wr(`T2C_OFF_IRQ_STAT, 32'h7);
         wr(`T2C_OFF_IRQ_MASK, 32'h4);
         wr(`T2C_OFF_CNT, 32'h00AB);
         wr(`T2C_OFF_CTRL, 32'h12);
         comparator0_in <= 1'b1;
         repeat (8) @(posedge clock);
         comparator0_in <= 1'b0;
         rdc(`T2C_OFF_RELOAD, 32'h00AB);
         rdc(`T2C_OFF_CTRL, 32'h92);
         irq_is(1'b1);
         // with code 00 the comparator is ignored and rtc/8 triggers instead
         wr(`T2C_OFF_CNT, 32'h00CD);
         wr(`T2C_OFF_CTRL, 32'h10);
         comparator0_in <= 1'b1;
         repeat (8) @(posedge clock);
         comparator0_in <= 1'b0;
         rdc(`T2C_OFF_RELOAD, 32'h00AB);
         rtc_pulses(8);
         repeat (8) @(posedge clock);
         rdc(`T2C_OFF_RELOAD, 32'h00CD);
      end
   endtask
   // split with run: low byte on the system clock, high byte on sys/12 and wrapping
   task s_hsplit;
      begin
         wr(`T2C_OFF_CTRL, 32'h0);
         wr(`T2C_OFF_IRQ_STAT, 32'h7);
         wr(`T2C_OFF_IRQ_MASK, 32'h1);
         wr(`T2C_OFF_CLKSEL, 32'h1);
         rdc(`T2C_OFF_CLKSEL, 32'h1);
         wr(`T2C_OFF_CNT, 32'hFF00);
         wr(`T2C_OFF_RELOAD, 32'h2000);
         wr(`T2C_OFF_CTRL, 32'h0C);
         poll(`T2C_OFF_CTRL, 32'h80);
         cmp(rd, 32'h8C);
         irq_is(1'b1);
         poll(`T2C_OFF_CNT, 32'hFF00);
         cmp(rd & 32'hFF00, 32'h2000);
         // a sys/12 low byte would show two counts at most by now
         cmp(rd[7:0] > 8'h02, 1'b1);
         // timer-level enable off must drop the pending request
         wr(`T2C_OFF_IRQ_EN, 32'h0);
         irq_is(1'b0);
      end
   endtask

   // -------------------------------------------------------------
   // run control
   // -------------------------------------------------------------
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, failures);
         if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // the whole run needs a few hundred cycles; this ceiling only stops a hang
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         failures = failures + 1;
         close_out;
      end
   end
   initial
   begin
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      s_regs;
      s_wrap16;
      s_split;
      s_rtc;
      s_capture;
      s_hsplit;
      close_out;
   end
endmodule // tb_top

bind t2c_timer t2c_timer_properties chk (.clock(clock), .resetn(resetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .rtc_clock_in(rtc_clock_in),
   .comparator0_in(comparator0_in), .irq(irq));
